// [core/pch_config_header.v]
`include "pch_defines.vh"
module pch_config_header
#(
   // Arbitrary revision value
   parameter [7:0] REVISION = 8'h5a
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire cfgWrite,
   input wire cfgRead,
   input wire [11:0] cfgAddr,
   input wire [31:0] cfgWdata,
   input wire [3:0] cfgBe,
   output reg [31:0] cfgRdata,
   input wire messagingUnitEnable,
   input wire targetImage0Enable,
   input wire pciAddrValid,
   input wire [31:0] pciAddr,
   output reg regSpaceHit,
   output reg [11:0] regSelect,
   output reg messagingHit,
   output reg messagingReservedHit,
   output reg [31:0] localBusAddr,
   output reg [3:0] lineWords,
   input wire masterStart,
   input wire masterActive,
   output reg masterTerminate,
   output reg [6:0] latencyTimerField
);
   reg [7:0] baseClass;
   reg [7:0] subClass;
   reg [7:0] programmingInterface;
   reg [1:0] cacheLineSizeField;
   reg [19:0] regSpaceBase;
   reg [15:0] image0Base;
   reg prefetchableFlag;
   reg meSync1;
   reg meSync2;
   reg teSync1;
   reg teSync2;
   wire expired;
   wire [31:0] classWord;
   wire [31:0] miscWord;
   wire [31:0] regBaseWord;
   wire [31:0] image0Word;
   reg [31:0] next_rdata;

   function hitOff;
      input [11:0] a;
      input [11:0] off;
      begin
         hitOff = (a[11:2] == off[11:2]);
      end
   endfunction

   function [7:0] mergeByte;
      input [7:0] old;
      input [7:0] nw;
      input be;
      begin
         mergeByte = be ? nw : old;
      end
   endfunction

   // Straps and enable come from outside the clock domain
   always @(posedge ref_clk)
   begin
      meSync1 <= messagingUnitEnable;
      meSync2 <= meSync1;
      teSync1 <= targetImage0Enable;
      teSync2 <= teSync1;
   end

   wire [11:0] regBaseOff = meSync2 ? `PCH_OFF_BAR2 : `PCH_OFF_BAR0;
   wire [11:0] image0Off = meSync2 ? `PCH_OFF_BAR0 : `PCH_OFF_BAR2;

   assign classWord = {baseClass, subClass, programmingInterface, REVISION};
   // Self-test, multifunction, layout all tied low
   assign miscWord = {8'h00, 8'h00, latencyTimerField, 1'b0,
                      4'h0, cacheLineSizeField, 2'b00};
   assign regBaseWord = {regSpaceBase, 12'h000};
   assign image0Word = teSync2 ? {image0Base, 12'h000, prefetchableFlag, 3'b000}
                               : 32'h00000000;

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         baseClass <= `PCH_BASE_BRIDGE;
         subClass <= `PCH_SUB_OTHER;
         programmingInterface <= `PCH_IFACE_RST;
         latencyTimerField <= `PCH_LATENCY_RST;
         cacheLineSizeField <= 2'b00;
         regSpaceBase <= 20'h00000;
         image0Base <= 16'h0000;
         prefetchableFlag <= 1'b0;
      end
      else if (cfgWrite)
      begin
         if (hitOff(cfgAddr, `PCH_OFF_CLASS))
         begin
            baseClass <= mergeByte(baseClass, cfgWdata[31:24], cfgBe[3]);
            if (cfgBe[2])
            begin
               // Messaging class forces messaging subclass
               if ((cfgBe[3] ? cfgWdata[31:24] : baseClass) == `PCH_BASE_MSG)
                  subClass <= `PCH_SUB_MSG;
               else
                  subClass <= cfgWdata[23:16];
            end
            if (cfgBe[1])
            begin
               if ((cfgBe[3] ? cfgWdata[31:24] : baseClass) == `PCH_BASE_MSG)
                  programmingInterface <= {7'h00, cfgWdata[8]};
               else
                  programmingInterface <= 8'h00;
            end
         end
         if (hitOff(cfgAddr, `PCH_OFF_MISC))
         begin
            if (cfgBe[1])
            begin
               if (cfgWdata[15:9] < `PCH_LATENCY_MIN)
                  latencyTimerField <= `PCH_LATENCY_MIN;
               else
                  latencyTimerField <= cfgWdata[15:9];
            end
            if (cfgBe[0])
            begin
               if (cfgWdata[3:2] == `PCH_LINESZ_4W || cfgWdata[3:2] == `PCH_LINESZ_8W)
                  cacheLineSizeField <= cfgWdata[3:2];
               else
                  cacheLineSizeField <= 2'b00;
            end
         end
         if (hitOff(cfgAddr, regBaseOff))
         begin
            regSpaceBase[19:12] <= mergeByte(regSpaceBase[19:12], cfgWdata[31:24], cfgBe[3]);
            regSpaceBase[11:4] <= mergeByte(regSpaceBase[11:4], cfgWdata[23:16], cfgBe[2]);
            if (cfgBe[1])
               regSpaceBase[3:0] <= cfgWdata[15:12];
         end
         if (hitOff(cfgAddr, image0Off) && teSync2)
         begin
            image0Base[15:8] <= mergeByte(image0Base[15:8], cfgWdata[31:24], cfgBe[3]);
            image0Base[7:0] <= mergeByte(image0Base[7:0], cfgWdata[23:16], cfgBe[2]);
            if (cfgBe[0])
               prefetchableFlag <= cfgWdata[3];
         end
      end
   end

   always @*
   begin
      next_rdata = 32'h00000000;
      if (hitOff(cfgAddr, `PCH_OFF_CLASS))
         next_rdata = classWord;
      else if (hitOff(cfgAddr, `PCH_OFF_MISC))
         next_rdata = miscWord;
      else if (hitOff(cfgAddr, regBaseOff))
         next_rdata = regBaseWord;
      else if (hitOff(cfgAddr, image0Off))
         next_rdata = image0Word;
   end

   always @(posedge ref_clk)
   begin
      if (!rst_n)
         cfgRdata <= 32'h00000000;
      else if (cfgRead)
         cfgRdata <= next_rdata;
   end

   // Decode: a zero base still decodes; software must program it first
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         regSpaceHit <= 1'b0;
         regSelect <= 12'h000;
         messagingHit <= 1'b0;
         messagingReservedHit <= 1'b0;
         localBusAddr <= 32'h00000000;
         lineWords <= `PCH_LINE_4W;
      end
      else
      begin
         regSpaceHit <= pciAddrValid && pciAddr[31:12] == regSpaceBase;
         regSelect <= pciAddr[11:0];
         messagingHit <= pciAddrValid && meSync2 && teSync2 &&
                         pciAddr[31:16] == image0Base && pciAddr[15:12] != 4'h0;
         messagingReservedHit <= pciAddrValid && meSync2 && teSync2 &&
                                 pciAddr[31:16] == image0Base &&
                                 pciAddr[15:12] == 4'h0;
         localBusAddr <= {16'h0000, pciAddr[15:0]} - `PCH_MSG_RSVD;
         // Same line length feeds target burst acceptance and DMA
         lineWords <= (cacheLineSizeField == `PCH_LINESZ_8W) ? `PCH_LINE_8W
                                                             : `PCH_LINE_4W;
      end
   end

   always @(posedge ref_clk)
   begin
      if (!rst_n)
         masterTerminate <= 1'b0;
      else
         masterTerminate <= expired;
   end

   pch_latency_timer u_pch_latency_timer
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(masterStart),
      .active(masterActive),
      .latencyField(latencyTimerField),
      .expired(expired)
   );
endmodule

// [core/pch_defines.vh]
`ifndef PCH_DEFINES_VH
`define PCH_DEFINES_VH
`define PCH_OFF_CLASS 12'h008
`define PCH_OFF_MISC 12'h00c
`define PCH_OFF_BAR0 12'h010
`define PCH_OFF_BAR2 12'h018
`define PCH_BASE_BRIDGE 8'h06
`define PCH_SUB_OTHER 8'h80
`define PCH_BASE_MSG 8'h0e
`define PCH_SUB_MSG 8'h00
`define PCH_IFACE_RST 8'h00
`define PCH_LATENCY_RST 7'h04
`define PCH_LATENCY_MIN 7'h04
`define PCH_LINESZ_4W 2'b01
`define PCH_LINESZ_8W 2'b10
`define PCH_LINE_4W 4'h4
`define PCH_LINE_8W 4'h8
`define PCH_REGSPACE_BITS 12
`define PCH_MSG_RSVD 32'h00001000
`endif

// [core/pch_latency_timer.v]
`include "pch_defines.vh"
module pch_latency_timer
(
   input wire ref_clk,
   input wire rst_n,
   input wire start,
   input wire active,
   input wire [6:0] latencyField,
   output reg expired
);
   reg [7:0] count;
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         count <= 8'h00;
         expired <= 1'b0;
      end
      else if (start)
      begin
         // Field counts in steps of two clocks
         count <= {latencyField, 1'b0};
         expired <= 1'b0;
      end
      else if (active && count != 8'h00)
      begin
         count <= count - 8'h01;
         expired <= (count == 8'h01);
      end
      else if (!active)
         expired <= 1'b0;
   end
endmodule

// [dv/pch_cfg_host.sv]
module pch_cfg_host
(
   input wire ref_clk,
   output logic cfgWrite,
   output logic cfgRead,
   output logic [11:0] cfgAddr,
   output logic [31:0] cfgWdata,
   output logic [3:0] cfgBe,
   input wire [31:0] cfgRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {cfgWrite, cfgRead, cfgAddr, cfgWdata, cfgBe} = '0;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      cfgWrite <= 1'b1;
      cfgAddr <= a;
      cfgWdata <= d;
      cfgBe <= 4'hf;
      @(posedge ref_clk);
      cfgWrite <= 1'b0;
      // Released lines wander so a stale value never passes
      cfgAddr <= ~a;
      cfgWdata <= ~d;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      cfgRead <= 1'b1;
      cfgAddr <= a;
      @(posedge ref_clk);
      cfgRead <= 1'b0;
      cfgAddr <= ~a;
      @(posedge ref_clk) #1;
      d = cfgRdata;
   endtask
endmodule

// [dv/pch_config_header_props.sv]
module pch_config_header_props
(
   input wire ref_clk,
   input wire rst_n,
   input wire cfgRead,
   input wire [11:0] cfgAddr,
   input wire [31:0] cfgRdata,
   input wire pciAddrValid,
   input wire [31:0] pciAddr,
   input wire regSpaceHit,
   input wire [11:0] regSelect,
   input wire messagingReservedHit,
   input wire [3:0] lineWords,
   input wire masterStart,
   input wire masterTerminate,
   input wire [6:0] latencyTimerField
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_line_size: assert property (lineWords == 4'h4 || lineWords == 4'h8)
      else $error("line size neither four nor eight words");
   chk_latency_min: assert property (latencyTimerField >= 7'h04)
      else $error("latency timer below eight clocks");
   chk_select_addr: assert property (
      pciAddrValid ##1 regSpaceHit |-> regSelect == $past(pciAddr[11:0]))
      else $error("register select differs from address");
   chk_reserved_low: assert property (
      pciAddrValid ##1 messagingReservedHit |-> $past(pciAddr[15:12]) == 4'h0)
      else $error("reserved hit above lowest 4K");
   chk_selftest_zero: assert property (
      cfgRead && cfgAddr == 12'h00c |=> cfgRdata[31:16] == 16'h0000)
      else $error("self-test or layout bits not zero");
   chk_misc_zero: assert property (
      cfgRead && cfgAddr == 12'h00c |=> cfgRdata[8:4] == 5'h00 && cfgRdata[1:0] == 2'h0)
      else $error("fixed zero bits of misc word set");
   chk_base_low: assert property (
      cfgRead && cfgAddr == 12'h010 |=> cfgRdata[11:4] == 8'h00 && cfgRdata[2:0] == 3'h0)
      else $error("base register low bits set");
   chk_term_late: assert property (masterStart |=> (!masterTerminate) [*7])
      else $error("transaction ended before latency ran out");
endmodule
bind pch_config_header pch_config_header_props u_pch_config_header_props (.ref_clk, .rst_n,
   .cfgRead, .cfgAddr, .cfgRdata, .pciAddrValid, .pciAddr, .regSpaceHit, .regSelect,
   .messagingReservedHit, .lineWords, .masterStart, .masterTerminate, .latencyTimerField);

// [dv/pch_config_header_tb.sv]
module pch_config_header_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic msgEn = 1'b0;
   logic img0En = 1'b1;
   logic pciAddrValid = 1'b0;
   logic [31:0] pciAddr = '0;
   logic masterStart = 1'b0;
   logic masterActive = 1'b0;
   wire cfgWrite, cfgRead, regSpaceHit, messagingHit, messagingReservedHit, masterTerminate;
   wire [11:0] cfgAddr, regSelect;
   wire [31:0] cfgWdata, cfgRdata, localBusAddr;
   wire [3:0] cfgBe, lineWords;
   wire [6:0] latencyTimerField;
   int error_cnt = 0;
   int check_count = 0;
   logic [31:0] rdata;
   always #10 ref_clk = ~ref_clk;
   pch_cfg_host u_pch_cfg_host (.ref_clk, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata, .cfgBe,
      .cfgRdata);
   pch_config_header #(.REVISION(8'h3c)) u_pch_config_header (.ref_clk, .rst_n, .cfgWrite,
      .cfgRead, .cfgAddr, .cfgWdata, .cfgBe, .cfgRdata, .messagingUnitEnable(msgEn),
      .targetImage0Enable(img0En), .pciAddrValid, .pciAddr, .regSpaceHit, .regSelect,
      .messagingHit, .messagingReservedHit, .localBusAddr, .lineWords, .masterStart,
      .masterActive, .masterTerminate, .latencyTimerField);
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      u_pch_cfg_host.rd(a, rdata);
      chk(rdata, exp);
   endtask
   task automatic dec(input logic [31:0] a);
      @(posedge ref_clk);
      pciAddrValid <= 1'b1;
      pciAddr <= a;
      @(posedge ref_clk);
      pciAddrValid <= 1'b0;
      pciAddr <= ~a;
      // Let the registered decode settle before it is judged
      #1;
   endtask
   task automatic t_reset_vals;
      rc(12'h008, 32'h0680_003c);
      rc(12'h00c, 32'h0000_0800);
      rc(12'h010, 32'h0);
      rc(12'h020, 32'h0);
      chk({lineWords, latencyTimerField}, {4'h4, 7'h04});
   endtask
   task automatic t_cache_line_size_field;
      for (int i = 0; i < 4; i++)
      begin
         u_pch_cfg_host.wr(12'h00c, {16'hffff, 7'h10, 1'b1, 4'hf, i[1:0], 2'b11});
         rc(12'h00c, {16'h0, 7'h10, 5'h0, (i == 3) ? 2'b00 : i[1:0], 2'b00});
         chk(lineWords, (i == 2) ? 4'h8 : 4'h4);
      end
   endtask
   task automatic t_latency;
      int n;
      u_pch_cfg_host.wr(12'h00c, 32'h0000_0400);
      rc(12'h00c, 32'h0000_0800);
      u_pch_cfg_host.wr(12'h00c, 32'h0000_0a00);
      @(posedge ref_clk);
      masterStart <= 1'b1;
      masterActive <= 1'b1;
      @(posedge ref_clk);
      masterStart <= 1'b0;
      #1;
      for (n = 0; n < 40 && masterTerminate !== 1'b1; n++)
         @(posedge ref_clk) #1;
      chk(n >= 9 && n <= 16, 1);
      @(posedge ref_clk);
      masterActive <= 1'b0;
   endtask
   task automatic t_bar;
      u_pch_cfg_host.wr(12'h010, 32'hffff_ffff);
      rc(12'h010, 32'hffff_f000);
      dec(32'hffff_f123);
      chk({regSpaceHit, regSelect}, {1'b1, 12'h123});
      dec(32'h1234_5678);
      chk(regSpaceHit, 0);
   endtask
   task automatic t_msg;
      @(posedge ref_clk);
      msgEn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rc(12'h018, 32'hffff_f000);
      u_pch_cfg_host.wr(12'h010, 32'habcd_000f);
      rc(12'h010, 32'habcd_0008);
      dec(32'habcd_0010);
      chk(messagingReservedHit, 1);
      dec(32'habcd_2010);
      chk({messagingHit, messagingReservedHit, localBusAddr}, {2'b10, 32'h1010});
      u_pch_cfg_host.wr(12'h008, 32'h0e55_01aa);
      rc(12'h008, 32'h0e00_013c);
      u_pch_cfg_host.wr(12'h008, 32'h0680_07aa);
      rc(12'h008, 32'h0680_003c);
      @(posedge ref_clk);
      img0En <= 1'b0;
      repeat (4) @(posedge ref_clk);
      u_pch_cfg_host.wr(12'h010, 32'h5555_0000);
      rc(12'h010, 32'h0);
   endtask
   task automatic final_report;
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset_vals;
      t_cache_line_size_field;
      t_latency;
      t_bar;
      t_msg;
      final_report;
   end
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      error_cnt++;
      final_report;
   end
endmodule
